// >>> inc/dma_crc_evt_pkg.sv
// shared constants for the dma crc routing and channel event control block
// assumes a 32-bit ahb-lite register bus and byte addresses below 0x40
package dma_crc_evt_pkg;
  // register byte offsets
  localparam logic [7:0]  OFF_CRC_CONTROL  = 8'h00;
  localparam logic [7:0]  OFF_CRC_RESULT   = 8'h04;
  localparam logic [7:0]  OFF_DEST_START   = 8'h08;
  localparam logic [7:0]  OFF_INT_STATUS   = 8'h0C;
  localparam logic [7:0]  OFF_INT_MASK     = 8'h10;
  localparam logic [7:0]  OFF_CHAN_ENABLE  = 8'h14;
  localparam logic [7:0]  OFF_CHAN_BUSY    = 8'h18;
  localparam logic [7:0]  OFF_EVENT_BASE   = 8'h20;
  // crc control fields
  localparam int          CRC_WBO_BIT      = 7;
  localparam int          CRC_APPEND_BIT   = 6;
  localparam int          CRC_KIND_BIT     = 5;
  localparam int          CRC_CH_LSB       = 0;
  localparam int          CRC_CH_W         = 3;
  // event control fields
  localparam int          EVT_ABORT_IRQ_LSB = 16;
  localparam int          EVT_START_IRQ_LSB = 8;
  localparam int          EVT_FORCE_BIT     = 7;
  localparam int          EVT_ABORT_BIT     = 6;
  localparam int          EVT_PATTERN_ABORT_ENABLE_BIT     = 5;
  localparam int          EVT_START_IRQ_ENABLE_BIT    = 4;
  localparam int          EVT_ABORT_IRQ_ENABLE_BIT    = 3;
  // interrupt status layout: abort flags low byte, start flags next byte
  localparam int          STAT_START_LSB    = 8;
  // reset values
  localparam logic [7:0]  IRQ_NUM_RESET     = 8'hFF;
  localparam logic [31:0] CRC_SEED          = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY          = 32'h04C11DB7;
  localparam logic [31:0] WORD_ZERO         = 32'h00000000;
  // ahb transfer types
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ        = 2'h3;
endpackage

// >>> rtl/crc_calc.sv
// crc engine: lfsr crc-32 or internet header checksum over 32-bit words
// assumes one word per cycle while feed is high; clear restarts the sum
`timescale 1ns/10ps
`default_nettype none
module crc_calc (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // control
  input  wire logic        clear,
  input  wire logic        kind_ip,
  // data
  input  wire logic        feed,
  input  wire logic [31:0] data,
  output logic      [31:0] result
);
  import dma_crc_evt_pkg::*;

  logic [31:0] lfsr_ff;     // running lfsr remainder
  logic [31:0] nxt_lfsr;
  logic [16:0] sum_ff;      // ones complement sum, bit 16 is carry
  logic [16:0] nxt_sum;

  // bitwise lfsr step, msb first; unrolled by the loop, one word per cycle
  always_comb begin
    logic [17:0] s;
    s = 18'h00000;
    nxt_lfsr = lfsr_ff;
    for (int i = 31; i >= 0; i--) begin
      if (nxt_lfsr[31] ^ data[i]) begin
        nxt_lfsr = {nxt_lfsr[30:0], 1'b0} ^ CRC_POLY;
      end else begin
        nxt_lfsr = {nxt_lfsr[30:0], 1'b0};
      end
    end
    // two halfwords plus folded carry; fold again so no carry is lost
    s = {2'b00, sum_ff[15:0]} + {2'b00, data[31:16]} + {2'b00, data[15:0]} + {17'h00000, sum_ff[16]};
    nxt_sum = {1'b0, s[15:0]} + {15'h0000, s[17:16]};
  end

  // state update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr_ff <= CRC_SEED;
      sum_ff  <= 17'h00000;
    end else if (clear) begin
      lfsr_ff <= CRC_SEED;
      sum_ff  <= 17'h00000;
    end else if (feed) begin
      lfsr_ff <= nxt_lfsr;
      sum_ff  <= nxt_sum;
    end
  end

  // result of the selected kind
  assign result = kind_ip ? {16'h0000, ~(sum_ff[15:0] + {15'h0000, sum_ff[16]})} : lfsr_ff;
endmodule
`default_nettype wire

// >>> rtl/chan_event_ctrl.sv
// one channel's event control register and start/abort decision
// assumes one interrupt number per cycle on irq_valid/irq_number
`timescale 1ns/10ps
`default_nettype none
module chan_event_ctrl (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // register write
  input  wire logic        wr_en,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata,
  // events
  input  wire logic        irq_valid,
  input  wire logic [7:0]  irq_number,
  input  wire logic        pattern_hit,
  // decisions
  output logic             start_evt,
  output logic             abort_evt,
  output logic             pattern_abort
);
  import dma_crc_evt_pkg::*;

  logic [7:0] abort_irq_number_ff;
  logic [7:0] start_irq_number_ff;
  logic       pattern_abort_enable_ff;
  logic       start_irq_enable_ff;
  logic       abort_irq_enable_ff;

  // stored fields; force and abort bits are not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abort_irq_number_ff     <= IRQ_NUM_RESET;
      start_irq_number_ff     <= IRQ_NUM_RESET;
      pattern_abort_enable_ff <= 1'b0;
      start_irq_enable_ff     <= 1'b0;
      abort_irq_enable_ff     <= 1'b0;
    end else if (wr_en) begin
      abort_irq_number_ff     <= wdata[EVT_ABORT_IRQ_LSB +: 8];
      start_irq_number_ff     <= wdata[EVT_START_IRQ_LSB +: 8];
      pattern_abort_enable_ff <= wdata[EVT_PATTERN_ABORT_ENABLE_BIT];
      start_irq_enable_ff     <= wdata[EVT_START_IRQ_ENABLE_BIT];
      abort_irq_enable_ff     <= wdata[EVT_ABORT_IRQ_ENABLE_BIT];
    end
  end

  // decisions, abort first so a start in the same cycle is dropped
  always_comb begin
    pattern_abort = pattern_hit && pattern_abort_enable_ff;
    abort_evt = (irq_valid && abort_irq_enable_ff && irq_number == abort_irq_number_ff)
                || (wr_en && wdata[EVT_ABORT_BIT])
                || pattern_abort;
    start_evt = ((irq_valid && start_irq_enable_ff && irq_number == start_irq_number_ff)
                 || (wr_en && wdata[EVT_FORCE_BIT]))
                && !abort_evt;
  end

  // readback; top byte and force/abort bits read zero
  assign rdata = {8'h00, abort_irq_number_ff, start_irq_number_ff, 2'b00,
                  pattern_abort_enable_ff, start_irq_enable_ff, abort_irq_enable_ff, 3'b000};
endmodule
`default_nettype wire

// >>> rtl/dma_crc_evt.sv
// dma crc routing, crc configuration and per-channel event control
// assumes an ahb-lite master, and a channel datapath that offers source
// words of the crc channel and reports block completion per channel
//
// Overview of operation
// - append mode: source feeds crc only
// - append: crc written to destination start address
// - no append: data to crc and destination
// - kind bit picks checksum or lfsr crc
// - three-bit field picks crc channel 0-7
// - append cannot be set while byte order set
// - abort irq number aborts, sets abort flag
// - start irq number begins channel transfer
// - event control top byte reads zero
// - force bit starts transfer, reads zero
// - abort bit aborts transfer, reads zero
// - pattern abort aborts and clears enable
// - abort irq honoured only when enabled
`timescale 1ns/10ps
`default_nettype none
module dma_crc_evt #(
  parameter int NUM_CH = 8  // channels with event control
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // interrupt events and pattern detect
  input  wire logic        irq_valid,
  input  wire logic [7:0]  irq_number,
  input  wire logic [NUM_CH-1:0] pattern_hit,
  input  wire logic [NUM_CH-1:0] block_done,
  // source words of the crc channel
  input  wire logic        src_valid,
  input  wire logic [31:0] src_data,
  output logic             src_ready,
  // destination writes
  output logic             dst_valid,
  output logic [31:0]      dst_data,
  output logic [31:0]      dst_addr,
  output logic             dst_is_crc,
  input  wire logic        dst_ready,
  // channel control outputs
  output logic [NUM_CH-1:0] chan_busy,
  output logic [NUM_CH-1:0] chan_start,
  output logic [NUM_CH-1:0] chan_abort,
  output logic [NUM_CH-1:0] channel_enable_bit,
  // interrupt
  output logic             irq
);
  import dma_crc_evt_pkg::*;

  // channels are limited by the three-bit select and the status layout
  if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
    $error("NUM_CH must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // word index of an event control register, or all ones if none
  function automatic logic [3:0] event_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFF_EVENT_BASE;
    if (a >= OFF_EVENT_BASE && d[7:2] < 6'(NUM_CH) && d[1:0] == 2'b00) begin
      event_index = {1'b0, d[4:2]};
    end else begin
      event_index = 4'hF;
    end
  endfunction

  // byte reversal for the alternate write byte order
  function automatic logic [31:0] swap_bytes(input logic [31:0] w);
    swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic              addr_phase; // valid address phase this cycle
  logic              wr_pend_ff; // write data phase pending
  logic [7:0]        wr_addr_ff; // latched write address
  logic [31:0]       hrdata_ff; // read data for data phase
  logic [31:0]       rd_mux; // read value of haddr
  logic [3:0]        wr_evt_idx; // event register hit by write

  logic              wbo_ff; // write byte order select
  logic              append_ff; // crc append select
  logic              kind_ff; // crc kind select
  logic [2:0]        crc_ch_ff; // crc channel select
  logic [31:0]       dest_start_ff; // destination start address
  logic [15:0]       int_status_ff; // sticky event flags
  logic [15:0]       int_mask_ff; // interrupt mask
  logic [NUM_CH-1:0] chan_en_ff; // channel enable bits
  logic [NUM_CH-1:0] busy_ff; // transfer in progress
  logic [NUM_CH-1:0] start_ff; // start pulse out
  logic [NUM_CH-1:0] abort_ff; // abort pulse out
  logic              irq_ff; // interrupt out

  logic [NUM_CH-1:0] ev_start; // per-channel start decision
  logic [NUM_CH-1:0] ev_abort; // per-channel abort decision
  logic [NUM_CH-1:0] ev_pat; // per-channel pattern abort
  logic [NUM_CH-1:0] go; // start accepted on enabled channel
  logic [31:0]       ev_rdata [NUM_CH]; // event register readback
  logic [15:0]       ev_flags; // events this cycle

  logic              crc_busy; // selected channel is moving data
  logic              crc_clear; // selected channel just started
  logic              take; // source word accepted
  logic              crc_done; // block done on crc channel
  logic [31:0]       crc_value; // engine result
  logic              dst_valid_ff;
  logic [31:0]       dst_data_ff;
  logic [31:0]       dst_addr_ff;
  logic              dst_crc_ff;
  logic              src_ready_ff;
  logic              nxt_dst_valid;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wr_evt_idx = event_index(wr_addr_ff);

  // latch write address; data arrives in the next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= addr_phase && hwrite;
      wr_addr_ff <= haddr;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    logic [3:0] ri;
    ri = event_index(haddr);
    rd_mux = WORD_ZERO;
    unique case (haddr)
      OFF_CRC_CONTROL: rd_mux = {24'h000000, wbo_ff, append_ff, kind_ff, 2'b00, crc_ch_ff};
      OFF_CRC_RESULT:  rd_mux = crc_value;
      OFF_DEST_START:  rd_mux = dest_start_ff;
      OFF_INT_STATUS:  rd_mux = {16'h0000, int_status_ff};
      OFF_INT_MASK:    rd_mux = {16'h0000, int_mask_ff};
      OFF_CHAN_ENABLE: rd_mux[NUM_CH-1:0] = chan_en_ff;
      OFF_CHAN_BUSY:   rd_mux[NUM_CH-1:0] = busy_ff;
      default: begin
        // event control registers sit in a strided window
        if (ri != 4'hF) begin
          rd_mux = ev_rdata[ri[2:0]];
        end
      end
    endcase
  end

  // read data registered at the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= WORD_ZERO;
    end else if (addr_phase && !hwrite) begin
      hrdata_ff <= rd_mux;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;   // never stalls; tied because no wait state exists
  assign hresp     = 1'b0;   // always okay

  ////////////////////////////////////////////////////////////////////////////
  // crc control, destination address, mask

  // crc control write; append is refused while the written byte order is 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wbo_ff    <= 1'b0;
      append_ff <= 1'b0;
      kind_ff   <= 1'b0;
      crc_ch_ff <= 3'h0;
    end else if (wr_pend_ff && wr_addr_ff == OFF_CRC_CONTROL) begin
      wbo_ff    <= hwdata[CRC_WBO_BIT];
      append_ff <= hwdata[CRC_APPEND_BIT] && !hwdata[CRC_WBO_BIT];
      kind_ff   <= hwdata[CRC_KIND_BIT];
      crc_ch_ff <= hwdata[CRC_CH_LSB +: CRC_CH_W];
    end
  end

  // plain read/write registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dest_start_ff <= WORD_ZERO;
      int_mask_ff   <= 16'h0000;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == OFF_DEST_START) begin
        dest_start_ff <= hwdata;
      end
      if (wr_addr_ff == OFF_INT_MASK) begin
        int_mask_ff <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel event control

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    chan_event_ctrl u_evt (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .wr_en         (wr_pend_ff && wr_evt_idx == 4'(c)),
      .wdata         (hwdata),
      .rdata         (ev_rdata[c]),
      .irq_valid     (irq_valid),
      .irq_number    (irq_number),
      .pattern_hit   (pattern_hit[c]),
      .start_evt     (ev_start[c]),
      .abort_evt     (ev_abort[c]),
      .pattern_abort (ev_pat[c])
    );
  end

  // a start only counts on an enabled channel
  assign go = ev_start & chan_en_ff;

  // channel enable; a pattern abort clears it and beats a same-cycle write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_en_ff <= '0;
    end else begin
      if (wr_pend_ff && wr_addr_ff == OFF_CHAN_ENABLE) begin
        chan_en_ff <= hwdata[NUM_CH-1:0];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (ev_pat[c]) begin
          chan_en_ff[c] <= 1'b0;
        end
      end
    end
  end

  // busy: abort or completion ends a transfer; a new start beats a completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_ff <= '0;
    end else begin
      busy_ff <= ((busy_ff & ~block_done) | go) & ~ev_abort;
    end
  end

  // one-cycle start and abort pulses to the channel datapath
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_ff <= '0;
      abort_ff <= '0;
    end else begin
      start_ff <= go;
      abort_ff <= ev_abort & busy_ff;
    end
  end

  assign chan_busy          = busy_ff;
  assign chan_start         = start_ff;
  assign chan_abort         = abort_ff;
  assign channel_enable_bit = chan_en_ff;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and output

  always_comb begin
    ev_flags = 16'h0000;
    ev_flags[NUM_CH-1:0] = ev_abort & busy_ff;
    ev_flags[STAT_START_LSB +: NUM_CH] = go;
  end

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status_ff <= 16'h0000;
    end else if (wr_pend_ff && wr_addr_ff == OFF_INT_STATUS) begin
      int_status_ff <= (int_status_ff & ~hwdata[15:0]) | ev_flags;
    end else begin
      int_status_ff <= int_status_ff | ev_flags;
    end
  end

  // level interrupt, one cycle behind the flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_status_ff & int_mask_ff);
    end
  end

  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // crc datapath

  assign crc_busy  = busy_ff[crc_ch_ff];
  assign crc_clear = go[crc_ch_ff];
  assign crc_done  = block_done[crc_ch_ff] && busy_ff[crc_ch_ff];
  assign take      = src_valid && src_ready_ff && crc_busy;

  crc_calc u_crc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clear   (crc_clear),
    .kind_ip (kind_ff),
    .feed    (take),
    .data    (src_data),
    .result  (crc_value)
  );

  // destination slot: pass-through words, or the crc word at block end
  always_comb begin
    nxt_dst_valid = dst_valid_ff && !dst_ready;
    if (take && !append_ff) begin
      nxt_dst_valid = 1'b1;
    end
    if (crc_done && append_ff) begin
      nxt_dst_valid = 1'b1;
    end
  end

  // destination register; source is taken only while the slot is free,
  // which halves throughput but keeps src_ready a plain flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dst_valid_ff <= 1'b0;
      dst_data_ff  <= WORD_ZERO;
      dst_addr_ff  <= WORD_ZERO;
      dst_crc_ff   <= 1'b0;
      src_ready_ff <= 1'b0;
    end else begin
      dst_valid_ff <= nxt_dst_valid;
      src_ready_ff <= !nxt_dst_valid && !(crc_done && append_ff);
      if (take && !append_ff) begin
        dst_data_ff <= wbo_ff ? swap_bytes(src_data) : src_data;
        dst_crc_ff  <= 1'b0;
      end else if (crc_done && append_ff) begin
        dst_data_ff <= crc_value;
        dst_addr_ff <= dest_start_ff;
        dst_crc_ff  <= 1'b1;
      end
    end
  end

  assign src_ready  = src_ready_ff;
  assign dst_valid  = dst_valid_ff;
  assign dst_data   = dst_data_ff;
  assign dst_addr   = dst_addr_ff;
  assign dst_is_crc = dst_crc_ff;
endmodule
`default_nettype wire

// >>> dv/dma_crc_evt_props.sv
// checker for the dma crc and event block, bound into the top module
// assumes channel 0 stands for all channels; sees top ports only
`timescale 1ns/10ps
`default_nettype none
module dma_crc_evt_props #(
  parameter int NUM_CH = 8  // channels
) (
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // bus
  input wire logic [1:0]        htrans,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // events
  input wire logic              irq_valid,
  input wire logic [NUM_CH-1:0] block_done,
  input wire logic [NUM_CH-1:0] chan_busy,
  input wire logic [NUM_CH-1:0] chan_start,
  input wire logic [NUM_CH-1:0] chan_abort,
  // stream
  input wire logic              src_ready,
  input wire logic              dst_valid,
  input wire logic              dst_ready,
  input wire logic [31:0]       dst_data,
  input wire logic [31:0]       dst_addr
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////////
  // destination word waiting, and taken
  sequence s_dst_wait; dst_valid && !dst_ready; endsequence
  sequence s_dst_take; dst_valid && dst_ready; endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  a_dst_hold: assert property (s_dst_wait |=> dst_valid && $stable(dst_data) && $stable(dst_addr))
    else $error("dst word changed");
  a_dst_release: assert property (s_dst_take |=> !dst_valid)
    else $error("dst word kept");
  a_src_refuse: assert property (dst_valid |-> !src_ready)
    else $error("src taken, slot full");
  a_start_busy: assert property (chan_start[0] |-> chan_busy[0])
    else $error("start, not busy");
  a_busy_rise: assert property ($rose(chan_busy[0]) |-> chan_start[0])
    else $error("busy rose, no start");
  a_abort_idle: assert property (chan_abort[0] |-> !chan_busy[0] && $past(chan_busy[0]))
    else $error("stray abort");
  a_busy_fall: assert property ($fell(chan_busy[0]) |-> chan_abort[0] || $past(block_done[0]))
    else $error("busy fell, no cause");
  // a force write in data phase could restart, so it is excluded
  a_done_ends: assert property (block_done[0] && chan_busy[0] && !irq_valid && !$past(htrans[1]) |=>
    !chan_busy[0]) else $error("done kept busy");
endmodule
bind dma_crc_evt dma_crc_evt_props #(.NUM_CH(NUM_CH)) u_props (.*);
`default_nettype wire

// >>> dv/dma_mem_model.sv
// memory model: offers source words, sinks destination writes
// assumes go offers words and slow stalls the sink every other cycle
`timescale 1ns/10ps
`default_nettype none
module dma_mem_model (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // bench control
  input  wire logic        go,
  input  wire logic        slow,
  // source side
  input  wire logic        src_ready,
  input  wire logic        take_ok,
  output logic             src_valid,
  output logic      [31:0] src_data,
  // destination side
  input  wire logic        dst_valid,
  input  wire logic [31:0] dst_data,
  input  wire logic [31:0] dst_addr,
  input  wire logic        dst_is_crc,
  output logic             dst_ready,
  // last destination write seen
  output int               n_dst,
  output logic      [31:0] last_dst,
  output logic      [31:0] last_addr,
  output logic             last_crc
);
  logic [15:0] idx_ff;  // index of word on offer
  logic        ph_ff;   // stall phase
  // idle line shows the inverse so a stale word never passes
  assign src_data = src_valid ? {16'hA5C3, idx_ff} : ~{16'hA5C3, idx_ff};
  ////////////////////////////////////////////////////////////////////////////
  // source holds its word until taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_valid <= 1'h0;
      idx_ff <= 16'h0000;
    end else begin
      src_valid <= go || (src_valid && !(src_ready && take_ok));
      if (src_valid && src_ready && take_ok) begin
        idx_ff <= idx_ff + 16'h0001;
      end
    end
  end
  // sink: ready always, or every other cycle when slow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_ff <= 1'h0;
      dst_ready <= 1'h0;
      n_dst <= 0;
      last_dst <= 32'h00000000;
      last_addr <= 32'h00000000;
      last_crc <= 1'h0;
    end else begin
      ph_ff <= ~ph_ff;
      dst_ready <= !slow || ph_ff;
      if (dst_valid && dst_ready) begin
        n_dst <= n_dst + 1;
        last_dst <= dst_data;
        last_addr <= dst_addr;
        last_crc <= dst_is_crc;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/dma_crc_and_channel_event_control_bench.sv
// bench: register and event sequences with expected values
// assumes one slave, so hready is its own hreadyout
`timescale 1ns/10ps
`default_nettype none
module dma_crc_and_channel_event_control_bench;
  import dma_crc_evt_pkg::*;
  localparam logic [7:0] E0 = OFF_EVENT_BASE;
  localparam logic [7:0] E1 = OFF_EVENT_BASE + 8'h04;
  logic        hclk, hresetn, hsel, hwrite, irq_valid, go, slow;
  logic        hreadyout, hresp, src_valid, src_ready, dst_valid, dst_is_crc, dst_ready, irq, last_crc;
  logic [1:0]  htrans;
  logic [7:0]  haddr, irq_number, pattern_hit, block_done, chan_busy, chan_start, chan_abort, chan_en;
  logic [31:0] hwdata, hrdata, src_data, dst_data, dst_addr, last_dst, last_addr;
  int          n_errors = 0, tests_run = 0, cyc = 0, n_dst, n;
  dma_crc_evt dut_u (.*, .hsize(3'h2), .hready(hreadyout), .channel_enable_bit(chan_en));
  dma_mem_model mem_u (.*, .take_ok(chan_busy[0]));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end
  // a hang ends the run as a failure
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one single ahb transfer, address phase then data phase; a read checks d
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    if (!w) chk(hrdata, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'h1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'h0, e);
  endtask
  // one-cycle event, returns mid-cycle after the answer
  task automatic ev(input logic [7:0] num, input logic v, input logic [7:0] p, input logic [7:0] b);
    @(posedge hclk);
    irq_valid <= v;
    irq_number <= num;
    pattern_hit <= p;
    block_done <= b;
    @(posedge hclk);
    irq_valid <= 1'h0;
    pattern_hit <= 8'h00;
    block_done <= 8'h00;
    @(negedge hclk);
  endtask
  task automatic settle();
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic waitn(input int m);
    repeat (400) if (n_dst < m) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, irq_valid, go, slow} = 6'h00;
    {haddr, irq_number, pattern_hit, block_done, htrans, hwdata} = 66'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    rd(E0, 32'h00FFFF00);
    rd(8'h1C, WORD_ZERO);
    wr(E1, 32'hFFFFFFFF);
    rd(E1, 32'h00FFFF38);
    chk(32'(chan_busy), WORD_ZERO);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_CRC_CONTROL, 32'(i));
      rd(OFF_CRC_CONTROL, 32'(i));
    end
    wr(OFF_CRC_CONTROL, 32'h000000E0);
    rd(OFF_CRC_CONTROL, 32'h000000A0);
    wr(OFF_CHAN_ENABLE, 32'h000000FF);
    wr(OFF_INT_MASK, WORD_ZERO);
    wr(E0, 32'h00FF0500);
    ev(8'h05, 1'h1, 8'h00, 8'h00);
    chk(32'(chan_start[0]), 32'h0);
    wr(E0, 32'h00FF0510);
    ev(8'h05, 1'h1, 8'h00, 8'h00);
    chk(32'(chan_start[0]), 32'h1);
    rd(OFF_INT_STATUS, 32'h00000100);
    chk(32'(irq), 32'h0);
    wr(OFF_INT_MASK, 32'h0000FFFF);
    settle();
    chk(32'(irq), 32'h1);
    ev(8'hFF, 1'h1, 8'h00, 8'h00);
    chk(32'(chan_abort[0]), 32'h0);
    wr(E0, 32'h00FF0518);
    ev(8'hFF, 1'h1, 8'h00, 8'h00);
    chk(32'(chan_abort[0]), 32'h1);
    rd(OFF_INT_STATUS, 32'h00000101);
    wr(OFF_INT_STATUS, 32'h00000101);
    settle();
    chk(32'(irq), 32'h0);
    rd(OFF_INT_STATUS, WORD_ZERO);
    wr(E0, 32'h00FF05D8);
    settle();
    chk(32'(chan_busy[0]), 32'h0);
    wr(E0, 32'h00FF0598);
    settle();
    chk(32'(chan_busy[0]), 32'h1);
    rd(E0, 32'h00FF0518);
    wr(E0, 32'h00FF0558);
    settle();
    chk(32'(chan_busy[0]), 32'h0);
    wr(E0, 32'h00FF05B0);
    ev(8'h00, 1'h0, 8'h01, 8'h00);
    chk(32'(chan_abort[0]), 32'h1);
    rd(OFF_CHAN_ENABLE, 32'h000000FE);
    chk(32'(chan_en), 32'h000000FE);
    wr(E1, 32'h00FF0580);
    ev(8'h00, 1'h0, 8'h02, 8'h00);
    chk(32'(chan_abort[1]), 32'h0);
    wr(E1, 32'h00FF0540);
    // pass-through with swapped bytes, sink stalling
    wr(OFF_CHAN_ENABLE, 32'h000000FF);
    wr(OFF_CRC_CONTROL, 32'h00000080);
    wr(E0, 32'h00FF0598);
    slow <= 1'h1;
    go <= 1'h1;
    waitn(1);
    chk(last_dst, 32'h0000C3A5);
    go <= 1'h0;
    wr(E0, 32'h00FF0558);
    repeat (8) @(posedge hclk);
    slow <= 1'h0;
    // append: no data words, then the crc at the start address
    wr(OFF_CRC_CONTROL, 32'h00000040);
    wr(OFF_DEST_START, 32'h00001234);
    n = n_dst;
    wr(E0, 32'h00FF0598);
    go <= 1'h1;
    repeat (12) @(posedge hclk);
    go <= 1'h0;
    repeat (4) @(posedge hclk);
    chk(32'(n_dst), 32'(n));
    ev(8'h00, 1'h0, 8'h00, 8'h01);
    waitn(n + 1);
    chk(last_addr, 32'h00001234);
    chk(32'(last_crc), 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
